// ==== include/tcu_pkg.sv ====
package tcu_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_COUNT  = 8'h08;
	localparam logic [7:0] OFF_CMP_A  = 8'h0c;
	localparam logic [7:0] OFF_CMP_B  = 8'h10;
	localparam logic [7:0] OFF_MASK   = 8'h14;
	localparam logic [7:0] OFF_FLAGS  = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRLA_WGM_LSB  = 0;
	localparam int CTRLB_CS_LSB   = 0;
	localparam int CTRLB_WGM2_POS = 3;
	localparam int FLAG_OVF       = 0;
	localparam int FLAG_CMP_A     = 1;
	localparam int FLAG_CMP_B     = 2;
	localparam int NUM_FLAGS      = 3;

	// ----------------------------------------------------------------
	// reset values and counter landmarks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_COUNT  = 8'h00;
	localparam logic [7:0] RST_CMP    = 8'h00;
	localparam logic [2:0] RST_CS     = 3'h0;
	localparam logic [2:0] RST_WGM    = 3'h0;
	localparam logic [2:0] RST_FLAGS  = 3'h0;
	localparam logic [2:0] RST_MASK   = 3'h0;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;

	// ----------------------------------------------------------------
	// clock select codes and prescaler divisors
	// ----------------------------------------------------------------
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRE_W    = 10;
	localparam int DIV_8    = 8;
	localparam int DIV_64   = 64;
	localparam int DIV_256  = 256;
	localparam int DIV_1024 = 1024;

	// ----------------------------------------------------------------
	// counting sequences
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_NORMAL    = 3'b000,
		MODE_PHASE_MAX = 3'b001,
		MODE_CTC       = 3'b010,
		MODE_FAST_MAX  = 3'b011,
		MODE_PHASE_CMP = 3'b101,
		MODE_FAST_CMP  = 3'b111
	} tcu_mode_t;

	typedef struct packed {
		logic bottom;
		logic max;
		logic top;
		logic matchA;
		logic matchB;
	} tcu_status_t;

endpackage : tcu_pkg

// ==== design/tcu_clock_select.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcu_clock_select (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// source selection
	input  wire logic [2:0] clockSelectField,
	input  wire logic       externalCountPin,
	// timer tick out
	output logic            timerTick
);

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	logic [tcu_pkg::PRE_W-1:0] preCount;
	logic                      pinMeta;
	logic                      pinSync;
	logic                      pinLast;

	// free running so that a source change needs no restart
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			preCount <= '0;
		end else begin
			preCount <= preCount + 1'b1;
		end
	end

	function automatic logic divTap(input logic [tcu_pkg::PRE_W-1:0] cnt, input int div);
		logic [tcu_pkg::PRE_W-1:0] mask;
		mask = tcu_pkg::PRE_W'(div - 1);
		return (cnt & mask) == mask;
	endfunction : divTap

	// ----------------------------------------------------------------
	// external pin: two flops, then edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			pinLast <= 1'b0;
		end else begin
			pinMeta <= externalCountPin;
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	always_comb begin
		unique case (clockSelectField)
			tcu_pkg::CS_STOP:     timerTick = 1'b0;
			tcu_pkg::CS_DIV1:     timerTick = 1'b1;
			tcu_pkg::CS_DIV8:     timerTick = divTap(preCount, tcu_pkg::DIV_8);
			tcu_pkg::CS_DIV64:    timerTick = divTap(preCount, tcu_pkg::DIV_64);
			tcu_pkg::CS_DIV256:   timerTick = divTap(preCount, tcu_pkg::DIV_256);
			tcu_pkg::CS_DIV1024:  timerTick = divTap(preCount, tcu_pkg::DIV_1024);
			tcu_pkg::CS_EXT_FALL: timerTick = pinLast & ~pinSync;
			tcu_pkg::CS_EXT_RISE: timerTick = ~pinLast & pinSync;
		endcase
	end

endmodule : tcu_clock_select
`default_nettype wire

// ==== design/tcu_compare.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcu_compare #(
	parameter int WIDTH = 8
) (
	// count and compare value
	input  wire logic [WIDTH-1:0] countValue,
	input  wire logic [WIDTH-1:0] compareValue,
	// timing
	input  wire logic             timerTick,
	input  wire logic             blocked,
	// results
	output logic                  match,
	output logic                  flagSet
);

	// refused at elaboration: a zero-width comparator has nothing to compare
	if (WIDTH < 1) begin : g_bad_width
		$error("tcu_compare: WIDTH must be at least 1");
	end

	assign match = (countValue == compareValue) & ~blocked;

	assign flagSet = match & timerTick;

endmodule : tcu_compare
`default_nettype wire

// ==== design/tcu_timer_top.sv ====
// How it works
// - counter and both compare values are 8-bit software read/write registers
// - overflow, compare A, compare B flags share one register, each with a mask bit
// - tick comes from prescaled clock or external pin, selected with edge
// - clock select zero gives no tick and the counter stands still
// - each compare value is compared with the counter at all times
// - a compare match sets its flag, which may raise the interrupt
// - bottom is signalled while the counter equals 0x00
// - max is 0xFF and is signalled when the counter reaches it
// - top is 0xFF or compare A, depending on the mode
// - each tick clears, increments or decrements the counter per mode and direction
// - software can read and write the counter with or without ticks
// - a software counter write wins over counting in the same cycle
// - 3-bit mode: two low bits in control A, high bit in control B
// - overflow flag is set at the point the mode defines
// - compare flag sets on the tick after the counter equalled the value
// - compare flag clears on interrupt service or on writing one
// - a counter write blocks compare matches until the next tick
`timescale 1ns/1ns
`default_nettype none
module tcu_timer_top (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     nrst,
	// ahb-lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	// external count source
	input  wire logic                     externalCountPin,
	// interrupt service acknowledge, one bit per flag
	input  wire logic [2:0]               intAck,
	// interrupt and counter state
	output logic                          irq,
	output var tcu_pkg::tcu_status_t      status
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] countValue;
	logic [7:0] compareAValue;
	logic [7:0] compareBValue;
	logic [2:0] clockSelectField;
	logic [2:0] waveformModeField;
	logic [2:0] timerFlagRegister;
	logic [2:0] timerMaskRegister;
	logic       countDown;
	logic       matchBlock;

	logic [7:0] next_count;
	logic       next_countDown;
	logic [7:0] topValue;
	logic       timerTick;
	logic       overflowEvent;
	logic       matchA;
	logic       matchB;
	logic       setA;
	logic       setB;
	logic [2:0] flagSet;
	logic [2:0] flagClear;

	// ----------------------------------------------------------------
	// ahb-lite front end
	// ----------------------------------------------------------------
	logic       addrPhase;
	logic       wrPend;
	logic       rdPend;
	logic [7:0] dataAddr;
	logic       dataInRange;
	logic       wrSel;
	logic [7:0] wrByte;
	logic [31:0] readMux;

	// hsize is not checked: only whole-word accesses are expected
	assign addrPhase = hsel & htrans[1] & hready;
	assign wrSel     = wrPend & dataInRange;
	assign wrByte    = hwdata[7:0];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrPend      <= 1'b0;
			rdPend      <= 1'b0;
			dataAddr    <= 8'h00;
			dataInRange <= 1'b0;
		end else begin
			wrPend <= addrPhase & hwrite;
			rdPend <= addrPhase & ~hwrite;
			if (addrPhase) begin
				dataAddr    <= haddr[7:0];
				dataInRange <= (haddr[31:8] == 24'h000000);
			end
		end
	end

	// reads take one wait state so a write just before is already visible
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			hresp <= 1'b0;
			if (addrPhase && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (rdPend) begin
				hreadyout <= 1'b1;
				hrdata    <= readMux;
			end
		end
	end

	always_comb begin
		readMux = 32'h00000000;
		if (dataInRange) begin
			unique case (dataAddr)
				tcu_pkg::OFF_CTRL_A: readMux = {30'h0, waveformModeField[1:0]};
				tcu_pkg::OFF_CTRL_B: readMux = {28'h0, waveformModeField[2], clockSelectField};
				tcu_pkg::OFF_COUNT:  readMux = {24'h0, countValue};
				tcu_pkg::OFF_CMP_A:  readMux = {24'h0, compareAValue};
				tcu_pkg::OFF_CMP_B:  readMux = {24'h0, compareBValue};
				tcu_pkg::OFF_MASK:   readMux = {29'h0, timerMaskRegister};
				tcu_pkg::OFF_FLAGS:  readMux = {29'h0, timerFlagRegister};
				default:             readMux = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control and compare registers
	// ----------------------------------------------------------------
	// split mode field
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			waveformModeField <= tcu_pkg::RST_WGM;
			clockSelectField  <= tcu_pkg::RST_CS;
		end else if (wrSel && dataAddr == tcu_pkg::OFF_CTRL_A) begin
			waveformModeField[1:0] <= wrByte[tcu_pkg::CTRLA_WGM_LSB +: 2];
		end else if (wrSel && dataAddr == tcu_pkg::OFF_CTRL_B) begin
			waveformModeField[2] <= wrByte[tcu_pkg::CTRLB_WGM2_POS];
			clockSelectField     <= wrByte[tcu_pkg::CTRLB_CS_LSB +: 3];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			compareAValue <= tcu_pkg::RST_CMP;
			compareBValue <= tcu_pkg::RST_CMP;
		end else if (wrSel && dataAddr == tcu_pkg::OFF_CMP_A) begin
			compareAValue <= wrByte;
		end else if (wrSel && dataAddr == tcu_pkg::OFF_CMP_B) begin
			compareBValue <= wrByte;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timerMaskRegister <= tcu_pkg::RST_MASK;
		end else if (wrSel && dataAddr == tcu_pkg::OFF_MASK) begin
			timerMaskRegister <= wrByte[2:0];
		end
	end

	// ----------------------------------------------------------------
	// tick source and comparators
	// ----------------------------------------------------------------
	tcu_clock_select u_clock_select (
		.ref_clk          (ref_clk),
		.nrst             (nrst),
		.clockSelectField (clockSelectField),
		.externalCountPin (externalCountPin),
		.timerTick        (timerTick)
	);

	tcu_compare #(.WIDTH(8)) u_compare_a (
		.countValue   (countValue),
		.compareValue (compareAValue),
		.timerTick    (timerTick),
		.blocked      (matchBlock),
		.match        (matchA),
		.flagSet      (setA)
	);

	tcu_compare #(.WIDTH(8)) u_compare_b (
		.countValue   (countValue),
		.compareValue (compareBValue),
		.timerTick    (timerTick),
		.blocked      (matchBlock),
		.match        (matchB),
		.flagSet      (setB)
	);

	// ----------------------------------------------------------------
	// counting sequence
	// ----------------------------------------------------------------
	// top per mode
	always_comb begin
		unique case (waveformModeField)
			tcu_pkg::MODE_CTC, tcu_pkg::MODE_PHASE_CMP, tcu_pkg::MODE_FAST_CMP: topValue = compareAValue;
			default: topValue = tcu_pkg::CNT_MAX;
		endcase
	end

	always_comb begin
		next_count     = countValue;
		next_countDown = countDown;
		overflowEvent  = 1'b0;
		unique case (tcu_pkg::tcu_mode_t'(waveformModeField))
			tcu_pkg::MODE_CTC: begin
				next_count    = (countValue == topValue) ? tcu_pkg::CNT_BOTTOM : countValue + 8'h01;
				overflowEvent = (countValue == tcu_pkg::CNT_MAX);
			end
			tcu_pkg::MODE_FAST_MAX, tcu_pkg::MODE_FAST_CMP: begin
				next_count    = (countValue == topValue) ? tcu_pkg::CNT_BOTTOM : countValue + 8'h01;
				overflowEvent = (countValue == topValue);
			end
			tcu_pkg::MODE_PHASE_MAX, tcu_pkg::MODE_PHASE_CMP: begin
				if (!countDown) begin
					next_countDown = (countValue == topValue);
					next_count     = next_countDown ? countValue - 8'h01 : countValue + 8'h01;
				end else begin
					next_countDown = (countValue != tcu_pkg::CNT_BOTTOM);
					next_count     = next_countDown ? countValue - 8'h01 : countValue + 8'h01;
					overflowEvent  = ~next_countDown;
				end
			end
			// normal, and reserved codes behave as normal
			default: begin
				next_count    = countValue + 8'h01;
				overflowEvent = (countValue == tcu_pkg::CNT_MAX);
			end
		endcase
	end

	logic wrCount;
	assign wrCount = wrSel && (dataAddr == tcu_pkg::OFF_COUNT);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			countValue <= tcu_pkg::RST_COUNT;
			countDown  <= 1'b0;
		end else if (wrCount) begin
			countValue <= wrByte;
		end else if (timerTick) begin
			countValue <= next_count;
			countDown  <= next_countDown;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			matchBlock <= 1'b0;
		end else if (wrCount) begin
			matchBlock <= 1'b1;
		end else if (timerTick) begin
			matchBlock <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// flags and interrupt
	// ----------------------------------------------------------------
	// match sets flag
	assign flagSet[tcu_pkg::FLAG_OVF]   = timerTick & ~wrCount & overflowEvent;
	assign flagSet[tcu_pkg::FLAG_CMP_A] = setA;
	assign flagSet[tcu_pkg::FLAG_CMP_B] = setB;
	assign flagClear = intAck | ((wrSel && dataAddr == tcu_pkg::OFF_FLAGS) ? wrByte[2:0] : 3'h0);

	// flags with masks
	// a set arriving with its clear wins, so no event is lost
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timerFlagRegister <= tcu_pkg::RST_FLAGS;
		end else begin
			timerFlagRegister <= (timerFlagRegister & ~flagClear) | flagSet;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(timerFlagRegister & timerMaskRegister);
		end
	end

	// ----------------------------------------------------------------
	// counter landmarks for the waveform generator
	// ----------------------------------------------------------------
	// bottom
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status <= '0;
		end else begin
			status.bottom <= (countValue == tcu_pkg::CNT_BOTTOM);
			status.max    <= (countValue == tcu_pkg::CNT_MAX);
			status.top    <= (countValue == topValue);
			status.matchA <= matchA;
			status.matchB <= matchB;
		end
	end

endmodule : tcu_timer_top
`default_nettype wire

// ==== tb/tcu_timer_top_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcu_timer_top_sva (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 nrst,
	// bus
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic [31:0]          hwdata,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire logic [31:0]          hrdata,
	// results
	input wire logic                 irq,
	input wire tcu_pkg::tcu_status_t status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic       pend;
	logic       pendWr;
	logic [7:0] pendAddr;
	logic [2:0] cs;
	logic [2:0] mode;
	logic [2:0] mask;
	logic [2:0] csQuiet;
	logic [2:0] wrQuiet;
	wire        take  = hsel & htrans[1] & hready;
	wire        wrNow = pend & pendWr & hready;
	wire        cntWr = wrNow & (pendAddr == tcu_pkg::OFF_COUNT);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend <= 1'b0;
			pendWr <= 1'b0;
			pendAddr <= 8'h00;
		end else if (hready) begin
			pend <= take & (haddr[31:8] == 24'h0);
			pendWr <= hwrite;
			pendAddr <= haddr[7:0];
		end
	end
	// shadow of the fields that gate the checks below
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cs <= 3'h0;
			mode <= 3'h0;
			mask <= 3'h0;
		end else if (wrNow) begin
			if (pendAddr == tcu_pkg::OFF_CTRL_A) mode[1:0] <= hwdata[1:0];
			if (pendAddr == tcu_pkg::OFF_CTRL_B) cs <= hwdata[2:0];
			if (pendAddr == tcu_pkg::OFF_CTRL_B) mode[2] <= hwdata[3];
			if (pendAddr == tcu_pkg::OFF_MASK) mask <= hwdata[2:0];
		end
	end
	// settle time: ticks already in the pipe may still land after a stop
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			csQuiet <= 3'h0;
			wrQuiet <= 3'h0;
		end else begin
			csQuiet <= (cs != tcu_pkg::CS_STOP) ? 3'h0 : ((csQuiet == 3'h7) ? csQuiet : csQuiet + 3'h1);
			wrQuiet <= cntWr ? 3'h0 : ((wrQuiet == 3'h7) ? wrQuiet : wrQuiet + 3'h1);
		end
	end
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_read_upper: assert property (take && !hwrite |-> ##2 hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_unmapped_zero: assert property (take && !hwrite && haddr[31:8] != 24'h0 |-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_mask_irq: assert property (mask == 3'h0 && $past(mask) == 3'h0 && $past(mask, 2) == 3'h0 |-> !irq)
		else $error("irq with all masked");
	a_stop_still: assert property (csQuiet == 3'h7 && wrQuiet >= 3'h4 |-> $stable(status.bottom) && $stable(status.max))
		else $error("counter moved while stopped");
	a_bottom_max: assert property (!(status.bottom && status.max)) else $error("bottom and max together");
	a_top_max: assert property (mode != 3'h2 && mode != 3'h5 && mode != 3'h7 && $past(mode) == mode
		|-> status.top == status.max) else $error("top differs from max");
	a_write_block: assert property (cntWr && csQuiet == 3'h7 |-> ##3 !status.matchA && !status.matchB)
		else $error("match shown after count write");
endmodule : tcu_timer_top_sva
bind tcu_timer_top tcu_timer_top_sva i_tcu_timer_top_sva (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .status(status));
`default_nettype wire

// ==== tb/timer8_counter_unit_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin mismatches++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module timer8_counter_unit_bench;
	logic                 ref_clk;
	logic                 nrst;
	logic                 hsel;
	logic                 hwrite;
	logic                 pin;
	logic                 hreadyout;
	logic                 hresp;
	logic                 irq;
	logic [31:0]          haddr;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic [31:0]          rd;
	logic [1:0]           htrans;
	logic [2:0]           intAck;
	logic [2:0]           m;
	logic [7:0]           v;
	logic [7:0]           ca;
	logic [8:0]           ex;
	logic [2:0]           modes[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7, 3'h4, 3'h6};
	tcu_pkg::tcu_status_t status;
	int                   mismatches;
	int                   numChecks;
	int                   cycles;
	int                   n;
	tcu_timer_top i_tcu_timer_top (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .externalCountPin(pin),
		.intAck(intAck), .irq(irq), .status(status));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic final_report;
		if (mismatches == 0 && numChecks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			final_report();
		end
	end
	// one single transfer; the address phase is held until hready is seen high
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, {24'h0, a}, {24'h0, d});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, {24'h0, a}, 32'h0);
		`CHK(nm, e, rd)
	endtask : rdc
	// one full pin pulse gives one tick on either selected edge
	task automatic pulse(input int k);
		repeat (k) begin
			pin <= 1'b1;
			repeat (6) @(posedge ref_clk);
			pin <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
	endtask : pulse
	// returns {overflow seen outside phase modes, final count}; phase modes turn at top and bottom
	function automatic logic [8:0] model(input logic [2:0] md, input logic [7:0] c, input int k, input logic [7:0] a);
		logic [7:0] top;
		logic       up;
		logic       ovf;
		top = (md == 3'h2 || md == 3'h5 || md == 3'h7) ? a : 8'hff;
		up = 1'b1;
		ovf = 1'b0;
		repeat (k) begin
			if (md == 3'h1 || md == 3'h5) begin
				if (c == top) up = 1'b0;
				else if (c == 8'h00) up = 1'b1;
				c = up ? c + 8'h1 : c - 8'h1;
			end else begin
				ovf |= (c == ((md == 3'h2) ? 8'hff : top));
				c = (c == top) ? 8'h00 : c + 8'h1;
			end
		end
		return {ovf, c};
	endfunction : model
	initial begin
		{nrst, hsel, hwrite, pin, haddr, hwdata, htrans, intAck} = '0;
		void'($urandom(32'h5dac));
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		for (int a = 0; a <= 24; a += 4) rdc(8'(a), 32'h0, "reset value");
		for (int a = 8; a <= 20; a += 4) begin
			v = 8'($urandom) & ((a == 20) ? 8'h07 : 8'hff);
			wr(8'(a), v);
			rdc(8'(a), {24'h0, v}, "readback");
		end
		wr(8'h1c, 8'hff);
		rdc(8'h1c, 32'h0, "unmapped");
		bus(1'b0, 32'h100, 32'h0);
		`CHK("far address", 32'h0, rd)
		wr(tcu_pkg::OFF_MASK, 8'h00);
		v = 8'($urandom);
		wr(tcu_pkg::OFF_CMP_A, v);
		wr(tcu_pkg::OFF_COUNT, v);
		pulse(2);
		repeat (20) @(posedge ref_clk);
		rdc(tcu_pkg::OFF_COUNT, {24'h0, v}, "stopped count");
		`CHK("stopped block", 1'b0, status.matchA)
		wr(tcu_pkg::OFF_CTRL_B, 8'h07);
		for (int u = 0; u < 2; u++) begin
			wr(u ? tcu_pkg::OFF_CMP_B : tcu_pkg::OFF_CMP_A, 8'h40);
			wr(tcu_pkg::OFF_COUNT, 8'h3f);
			wr(tcu_pkg::OFF_FLAGS, 8'h07);
			pulse(1);
			bus(1'b0, {24'h0, tcu_pkg::OFF_FLAGS}, 32'h0);
			`CHK("flag early", 1'b0, rd[u+1])
			`CHK("match level", 1'b1, u ? status.matchB : status.matchA)
			pulse(1);
			bus(1'b0, {24'h0, tcu_pkg::OFF_FLAGS}, 32'h0);
			`CHK("flag set", 1'b1, rd[u+1])
			`CHK("irq masked", 1'b0, irq)
			wr(tcu_pkg::OFF_MASK, 8'(2 << u));
			repeat (3) @(posedge ref_clk);
			`CHK("irq raised", 1'b1, irq)
			if (u == 0) begin
				intAck <= 3'h2;
				@(posedge ref_clk);
				intAck <= 3'h0;
			end else wr(tcu_pkg::OFF_FLAGS, 8'h04);
			repeat (3) @(posedge ref_clk);
			`CHK("irq cleared", 1'b0, irq)
			wr(tcu_pkg::OFF_MASK, 8'h00);
		end
		wr(tcu_pkg::OFF_CMP_A, 8'h50);
		wr(tcu_pkg::OFF_COUNT, 8'h50);
		wr(tcu_pkg::OFF_FLAGS, 8'h07);
		pulse(2);
		bus(1'b0, {24'h0, tcu_pkg::OFF_FLAGS}, 32'h0);
		`CHK("blocked match", 1'b0, rd[1])
		foreach (modes[i]) begin
			m = modes[i];
			ca = 8'($urandom_range(2, 6));
			v = (m == 3'h2 || m == 3'h5 || m == 3'h7) ? 8'h00 : 8'hfc;
			n = $urandom_range(1, 10);
			wr(tcu_pkg::OFF_CMP_A, ca);
			wr(tcu_pkg::OFF_CTRL_A, {6'h0, m[1:0]});
			wr(tcu_pkg::OFF_CTRL_B, {4'h0, m[2], (i % 2 == 1) ? 3'h6 : 3'h7});
			wr(tcu_pkg::OFF_COUNT, v);
			wr(tcu_pkg::OFF_FLAGS, 8'h07);
			pulse(n);
			ex = model(m, v, n, ca);
			rdc(tcu_pkg::OFF_COUNT, {24'h0, ex[7:0]}, "count");
			`CHK("bottom", ex[7:0] == 8'h00, status.bottom)
			`CHK("max", ex[7:0] == 8'hff, status.max)
			bus(1'b0, {24'h0, tcu_pkg::OFF_FLAGS}, 32'h0);
			if (m != 3'h1 && m != 3'h5) `CHK("overflow", ex[8], rd[0])
		end
		// back to normal counting so a short top cannot wrap the count to zero
		wr(tcu_pkg::OFF_CTRL_A, 8'h00);
		for (int c = 1; c <= 5; c++) begin
			wr(tcu_pkg::OFF_CTRL_B, 8'(c));
			wr(tcu_pkg::OFF_COUNT, 8'h00);
			if (c == 1) begin
				bus(1'b0, {24'h0, tcu_pkg::OFF_COUNT}, 32'h0);
				`CHK("write wins", 8'h01, rd[7:0])
			end
			repeat (1100) @(posedge ref_clk);
			bus(1'b0, {24'h0, tcu_pkg::OFF_COUNT}, 32'h0);
			`CHK("prescaled run", 1'b1, rd[7:0] != 8'h00)
		end
		final_report();
	end
endmodule : timer8_counter_unit_bench
`undef CHK
`default_nettype wire
